// File: chan2_deadtime_offstate_override.sv
// channel 2 off-state and dead-time override, with its register and output gating
// assumes all inputs are synchronous to core_clk_i and the shared register lives outside
`timescale 1ns/1ns
`default_nettype none

module chan2_deadtime_offstate_override (
	// clock, reset, enable
	input  wire logic        core_clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        clk_en_i,
	// register port
	input  wire logic [7:0]  addr_i,
	input  wire logic [31:0] wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic      [31:0] rdata_o,
	// shared break and dead-time register fields
	input  wire logic [1:0]  lock_level_i,
	input  wire logic        shared_run_off_state_i,
	input  wire logic        shared_idle_off_state_i,
	input  wire logic [7:0]  shared_dead_time_code_i,
	input  wire logic        primary_output_enable_i,
	// channel control
	input  wire logic        chan2_main_enable_i,
	input  wire logic        chan2_compl_enable_i,
	input  wire logic        chan2_output_mode_i,
	input  wire logic        chan2_ref_i,
	// channel outputs
	output logic             chan2_main_out_o,
	output logic             chan2_main_oe_o,
	output logic             chan2_compl_out_o,
	output logic             chan2_compl_oe_o
);

	// ****************************************
	// register fields
	// ****************************************
	logic        override_select_reg;
	logic        run_off_state_reg;
	logic        idle_off_state_reg;
	logic [7:0]  dead_time_code_reg;

	logic        wr_override;
	logic        lock_open;
	logic        lock_high;

	// effective settings after the source choice
	logic        eff_run_off;
	logic        eff_idle_off;
	logic [7:0]  eff_code;
	logic [9:0]  dt_length;

	// inserter outputs
	logic        main_raw;
	logic        compl_raw;
	logic        dt_busy;

	// output gating
	logic        out_enabled;
	logic        main_oe_next;
	logic        compl_oe_next;
	logic        main_out_next;
	logic        compl_out_next;

	// ****************************************
	// register write decode
	// ****************************************

	// only whole-word writes at the one offset exist on this port
	assign wr_override = clk_en_i && wr_i && (addr_i == chan2_dt_pkg::OFS_OVERRIDE);
	assign lock_open   = (lock_level_i == chan2_dt_pkg::LOCK_OPEN);
	assign lock_high   = lock_level_i[1];

	// select bit, writable only with the lock fully open
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			override_select_reg <= chan2_dt_pkg::OVERRIDE_RST[chan2_dt_pkg::BIT_SELECT];
		end else if (wr_override && lock_open) begin
			override_select_reg <= wdata_i[chan2_dt_pkg::BIT_SELECT];
		end
	end

	// off-state bits survive lock level 01 but freeze at 10 and 11
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			run_off_state_reg  <= chan2_dt_pkg::OVERRIDE_RST[chan2_dt_pkg::BIT_RUN_OFF];
			idle_off_state_reg <= chan2_dt_pkg::OVERRIDE_RST[chan2_dt_pkg::BIT_IDLE_OFF];
		end else if (wr_override && !lock_high) begin
			run_off_state_reg  <= wdata_i[chan2_dt_pkg::BIT_RUN_OFF];
			idle_off_state_reg <= wdata_i[chan2_dt_pkg::BIT_IDLE_OFF];
		end
	end

	// dead-time code, writable only with the lock fully open
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			dead_time_code_reg <= chan2_dt_pkg::OVERRIDE_RST[chan2_dt_pkg::CODE_MSB:chan2_dt_pkg::CODE_LSB];
		end else if (wr_override && lock_open) begin
			dead_time_code_reg <= wdata_i[chan2_dt_pkg::CODE_MSB:chan2_dt_pkg::CODE_LSB];
		end
	end

	// ****************************************
	// register read
	// ****************************************

	// reserved bits are not stored, so they always read back as their reset zero
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			rdata_o <= 32'h0000_0000;
		end else if (clk_en_i) begin
			rdata_o <= 32'h0000_0000;
			if (rd_i && addr_i == chan2_dt_pkg::OFS_OVERRIDE) begin
				rdata_o[chan2_dt_pkg::BIT_SELECT]   <= override_select_reg;
				rdata_o[chan2_dt_pkg::BIT_RUN_OFF]  <= run_off_state_reg;
				rdata_o[chan2_dt_pkg::BIT_IDLE_OFF] <= idle_off_state_reg;
				rdata_o[chan2_dt_pkg::CODE_MSB:chan2_dt_pkg::CODE_LSB] <= dead_time_code_reg;
			end else if (rd_i && addr_i == chan2_dt_pkg::OFS_STATUS) begin
				rdata_o[chan2_dt_pkg::BIT_ST_MAIN]  <= chan2_main_out_o;
				rdata_o[chan2_dt_pkg::BIT_ST_COMPL] <= chan2_compl_out_o;
				rdata_o[chan2_dt_pkg::BIT_ST_BUSY]  <= dt_busy;
				rdata_o[chan2_dt_pkg::BIT_ST_SRC]   <= override_select_reg;
				rdata_o[chan2_dt_pkg::ST_LEN_MSB:chan2_dt_pkg::ST_LEN_LSB] <= dt_length;
			end
		end
	end

	// ****************************************
	// source selection and dead time
	// ****************************************

	// the whole group switches source at once so no mixed settings appear
	assign eff_run_off  = override_select_reg ? run_off_state_reg  : shared_run_off_state_i;
	assign eff_idle_off = override_select_reg ? idle_off_state_reg : shared_idle_off_state_i;
	assign eff_code     = override_select_reg ? dead_time_code_reg : shared_dead_time_code_i;

	dt_code_decoder u_decoder (
		.code_i   (eff_code),
		.length_o (dt_length)
	);

	dt_edge_delay u_delay (
		.core_clk_i  (core_clk_i),
		.rst_n_i     (rst_n_i),
		.clk_en_i    (clk_en_i),
		.ref_i       (chan2_ref_i),
		.length_i    (dt_length),
		.main_raw_o  (main_raw),
		.compl_raw_o (compl_raw),
		.busy_o      (dt_busy)
	);

	// ****************************************
	// off-state gating
	// ****************************************

	// run mode uses the run bit, idle mode the idle bit; input mode never drives
	assign out_enabled = chan2_output_mode_i &&
	                     (primary_output_enable_i ? eff_run_off : eff_idle_off);

	// in run mode an enabled pin whose channel enable is low drives its inactive level; in idle mode that pin is disabled
	always_comb begin
		main_oe_next   = out_enabled && (primary_output_enable_i || chan2_main_enable_i);
		compl_oe_next  = out_enabled && (primary_output_enable_i || chan2_compl_enable_i);
		main_out_next  = out_enabled && primary_output_enable_i
		                 && chan2_main_enable_i && main_raw;
		compl_out_next = out_enabled && primary_output_enable_i
		                 && chan2_compl_enable_i && compl_raw;
	end

	// registered pins keep the gating glitch free
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			chan2_main_out_o  <= 1'b0;
			chan2_main_oe_o   <= 1'b0;
			chan2_compl_out_o <= 1'b0;
			chan2_compl_oe_o  <= 1'b0;
		end else if (clk_en_i) begin
			chan2_main_out_o  <= main_out_next;
			chan2_main_oe_o   <= main_oe_next;
			chan2_compl_out_o <= compl_out_next;
			chan2_compl_oe_o  <= compl_oe_next;
		end
	end

	// ****************************************
	// assertions
	// ****************************************

	a_select_lock_hold: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		wr_override && !lock_open |=> $stable(override_select_reg))
		else $error("select bit changed while locked");

	a_select_write_open: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		wr_override && lock_open |=> override_select_reg == $past(wdata_i[31]))
		else $error("select bit not written while open");

	a_offstate_lock_hold: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		wr_override && lock_level_i[1] |=> $stable(run_off_state_reg) && $stable(idle_off_state_reg))
		else $error("off-state bits changed at high lock");

	a_partial_write_mix: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		wr_override && lock_level_i == 2'b01
		|=> $stable(dead_time_code_reg) && run_off_state_reg == $past(wdata_i[11]))
		else $error("partial lock write wrong");

	a_code_lock_hold: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		wr_override && !lock_open |=> $stable(dead_time_code_reg))
		else $error("dead-time code changed while locked");

	a_reset_zero_state: assert property (@(posedge core_clk_i)
		!rst_n_i |=> !override_select_reg && !run_off_state_reg
		             && !idle_off_state_reg && dead_time_code_reg == 8'h00)
		else $error("override register not zero after reset");

	a_run_disable_pins: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		clk_en_i && primary_output_enable_i && !eff_run_off
		|=> !chan2_main_oe_o && !chan2_compl_oe_o && !chan2_main_out_o)
		else $error("run off-state 0 did not disable outputs");

	a_idle_disable_pins: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		clk_en_i && !primary_output_enable_i && !eff_idle_off
		|=> !chan2_main_oe_o && !chan2_compl_oe_o)
		else $error("idle off-state 0 did not disable outputs");

	a_source_follow: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		!override_select_reg && shared_dead_time_code_i == 8'h05 |-> dt_length == 10'h005)
		else $error("shared code not used with select clear");

	a_decode_short: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		!eff_code[7] |-> dt_length == {2'h0, eff_code})
		else $error("short code length wrong");

	a_decode_double: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		eff_code[7:6] == 2'b10 |-> dt_length == 10'((7'd64 + eff_code[5:0]) * 2))
		else $error("double step length wrong");

	a_decode_eight: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		eff_code[7:5] == 3'b110 |-> dt_length == 10'((6'd32 + eff_code[4:0]) * 8))
		else $error("eight step length wrong");

	a_decode_sixteen: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		eff_code[7:5] == 3'b111 |-> dt_length == 10'((6'd32 + eff_code[4:0]) * 16))
		else $error("sixteen step length wrong");

	a_no_overlap_pins: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		!(chan2_main_out_o && chan2_compl_out_o))
		else $error("main and complement high together");

	a_dead_gap_two: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		clk_en_i && compl_raw && dt_length == 10'd2 && chan2_ref_i
		##1 clk_en_i[*2] |-> !main_raw)
		else $error("main drive came before the dead time");

	a_read_reserved_zero: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		clk_en_i && rd_i && addr_i == chan2_dt_pkg::OFS_OVERRIDE
		|=> rdata_o[30:12] == 19'h0 && rdata_o[9:8] == 2'h0)
		else $error("reserved bits read nonzero");

	c_override_taken: cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
		wr_override && lock_open && wdata_i[31]);

	c_run_mode_drive: cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
		chan2_main_out_o ##[1:40] chan2_compl_out_o);

	c_long_dead_time: cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
		eff_code[7:5] == 3'b111 && dt_busy);

	c_idle_enabled: cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
		!primary_output_enable_i && chan2_main_oe_o);

endmodule

`default_nettype wire

// File: chan2_deadtime_offstate_override_tb.sv
// self-checking bench for the channel 2 off-state and dead-time override block
// assumes the design files and chan2_dt_pkg are compiled first; base period is one clock
`timescale 1ns/1ns
`default_nettype none

module chan2_deadtime_offstate_override_tb;

	// ****************************************
	// stimulus and observed signals
	// ****************************************
	logic        core_clk_i = 1'b0;
	logic        rst_n_i = 1'b0;
	logic        clk_en_i = 1'b1;
	logic [7:0]  addr_i = 8'h00;
	logic [31:0] wdata_i = 32'h0000_0000;
	logic        wr_i = 1'b0;
	logic        rd_i = 1'b0;
	logic [1:0]  lock_level_i = 2'b00;
	logic        shared_run_off_state_i = 1'b1;
	logic        shared_idle_off_state_i = 1'b1;
	logic [7:0]  shared_dead_time_code_i = 8'h05;
	logic        primary_output_enable_i = 1'b1;
	logic        chan2_main_enable_i = 1'b1;
	logic        chan2_compl_enable_i = 1'b1;
	logic        chan2_output_mode_i = 1'b1;
	logic        chan2_ref_i = 1'b0;
	logic [31:0] rdata_o;
	logic        chan2_main_out_o;
	logic        chan2_main_oe_o;
	logic        chan2_compl_out_o;
	logic        chan2_compl_oe_o;
	int          n_mismatch = 0;
	int          n_compared = 0;
	int          cycle_cnt = 0;

	// table rows: dead-time code and its length in base periods
	logic [7:0]  row_code [8] = '{8'h00, 8'h7F, 8'h80, 8'hBF, 8'hC0, 8'hDF, 8'hE0, 8'hFF};
	logic [9:0]  row_len  [8] = '{10'h000, 10'h07F, 10'h080, 10'h0FE,
	                              10'h100, 10'h1F8, 10'h200, 10'h3F0};

	chan2_deadtime_offstate_override u_chan2_deadtime_offstate_override (
		.core_clk_i              (core_clk_i),
		.rst_n_i                 (rst_n_i),
		.clk_en_i                (clk_en_i),
		.addr_i                  (addr_i),
		.wdata_i                 (wdata_i),
		.wr_i                    (wr_i),
		.rd_i                    (rd_i),
		.rdata_o                 (rdata_o),
		.lock_level_i            (lock_level_i),
		.shared_run_off_state_i  (shared_run_off_state_i),
		.shared_idle_off_state_i (shared_idle_off_state_i),
		.shared_dead_time_code_i (shared_dead_time_code_i),
		.primary_output_enable_i (primary_output_enable_i),
		.chan2_main_enable_i     (chan2_main_enable_i),
		.chan2_compl_enable_i    (chan2_compl_enable_i),
		.chan2_output_mode_i     (chan2_output_mode_i),
		.chan2_ref_i             (chan2_ref_i),
		.chan2_main_out_o        (chan2_main_out_o),
		.chan2_main_oe_o         (chan2_main_oe_o),
		.chan2_compl_out_o       (chan2_compl_out_o),
		.chan2_compl_oe_o        (chan2_compl_oe_o)
	);

	// ****************************************
	// clock, timeout and shared tasks
	// ****************************************
	// 4 ns period
	always #2 core_clk_i = ~core_clk_i;

	// the whole run needs well under a thousand cycles; a hang is cut at 4000
	always @(posedge core_clk_i) begin
		cycle_cnt <= cycle_cnt + 1;
		if (cycle_cnt == 4000) begin
			n_mismatch = n_mismatch + 1;
			$display("FAIL at %0t: run did not finish in time", $time);
			print_verdict();
		end
	end

	task automatic check_word(input logic [31:0] got, input logic [31:0] exp, input string msg);
		n_compared = n_compared + 1;
		if (got !== exp) begin
			n_mismatch = n_mismatch + 1;
			$display("FAIL at %0t: %s got %h expected %h", $time, msg, got, exp);
		end
	endtask

	// outputs packed as {main_oe, main_out, compl_oe, compl_out}
	task automatic check_pins(input logic [3:0] exp, input string msg);
		check_word({28'h0, chan2_main_oe_o, chan2_main_out_o, chan2_compl_oe_o,
			chan2_compl_out_o}, {28'h0, exp}, msg);
	endtask

	task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge core_clk_i);
		wr_i <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe, so sample there
	task automatic reg_read(input logic [7:0] a, input logic [31:0] mask,
		input logic [31:0] exp, input string msg);
		@(posedge core_clk_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge core_clk_i);
		rd_i <= 1'b0;
		#1;
		check_word(rdata_o & mask, exp, msg);
	endtask

	// let a gating change pass through the output registers
	task automatic settle();
		repeat (2) @(posedge core_clk_i);
		#1;
	endtask

	task automatic print_verdict();
		$display("comparisons %0d, mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		repeat (3) @(posedge core_clk_i);
		rst_n_i <= 1'b1;
		// reset state and shared source
		reg_read(8'h84, 32'hFFFF_FFFF, 32'h0000_0000, "reset value");
		reg_read(8'h90, 32'h0000_3FF8, 32'h0000_0050, "shared code length");
		shared_dead_time_code_i <= 8'hA3;
		reg_read(8'h90, 32'h0000_3FF8, {18'h0, 10'd198, 4'h0}, "shared 10x length");
		$display("test reset done");

		// ordinary rows: each code range through the override copy
		for (int i = 0; i < 8; i++) begin
			reg_write(8'h84, {1'b1, 19'h0, 4'hC, row_code[i]});
			reg_read(8'h84, 32'hFFFF_FFFF, {1'b1, 19'h0, 4'hC, row_code[i]}, "readback");
			reg_read(8'h90, 32'h0000_3FF8, {18'h0, row_len[i], 4'h8}, "decoded length");
		end
		$display("test code table done");

		// lock level 01 blocks select and code, not the off-state bits
		lock_level_i <= 2'b01;
		reg_write(8'h84, 32'h0000_0011);
		reg_read(8'h84, 32'hFFFF_FFFF, 32'h8000_00FF, "lock 01");
		for (int lv = 2; lv < 4; lv++) begin
			lock_level_i <= lv[1:0];
			reg_write(8'h84, 32'h0000_0C22);
			reg_read(8'h84, 32'hFFFF_FFFF, 32'h8000_00FF, "lock 1x");
		end
		lock_level_i <= 2'b00;
		reg_write(8'h84, 32'h7FFF_FF02);
		reg_read(8'h84, 32'hFFFF_FFFF, 32'h0000_0C02, "reserved bits");
		reg_write(8'h88, 32'h8000_0000);
		reg_read(8'h88, 32'hFFFF_FFFF, 32'h0000_0000, "unmapped read");
		reg_read(8'h84, 32'hFFFF_FFFF, 32'h0000_0C02, "unmapped write");
		$display("test lock done");

		// off-state source and gating
		shared_run_off_state_i <= 1'b0;
		settle();
		check_pins(4'b0000, "shared run off");
		reg_write(8'h84, 32'h8000_0C02);
		settle();
		check_pins(4'b1011, "override run on");
		chan2_output_mode_i <= 1'b0;
		settle();
		check_pins(4'b0000, "input mode");
		chan2_output_mode_i <= 1'b1;
		primary_output_enable_i <= 1'b0;
		settle();
		check_pins(4'b1010, "idle on");
		reg_write(8'h84, 32'h8000_0802);
		settle();
		check_pins(4'b0000, "idle off");
		reg_write(8'h84, 32'h8000_0402);
		primary_output_enable_i <= 1'b1;
		settle();
		check_pins(4'b0000, "run off");
		$display("test gating done");

		// dead time of two base periods on both edges
		reg_write(8'h84, 32'h8000_0C02);
		settle();
		@(posedge core_clk_i);
		chan2_ref_i <= 1'b1;
		repeat (2) @(posedge core_clk_i);
		#1;
		check_pins(4'b1010, "compl released");
		@(posedge core_clk_i);
		#1;
		check_pins(4'b1010, "main held off");
		@(posedge core_clk_i);
		#1;
		check_pins(4'b1110, "main active");
		chan2_ref_i <= 1'b0;
		repeat (2) @(posedge core_clk_i);
		#1;
		check_pins(4'b1010, "main released");
		repeat (2) @(posedge core_clk_i);
		#1;
		check_pins(4'b1011, "compl active");
		$display("test dead time done");
		print_verdict();
	end

endmodule

`default_nettype wire

// File: chan2_dt_pkg.sv
// constants, field layout and state codes for the channel 2 override block
// assumes a single 250 MHz timer clock and a word-wide register port
//
// Summary of operation
// - select bit 0 takes off-state and dead-time settings from the shared register, 1 from this one.
// - the select bit is written only while the shared lock level is 00.
// - with primary output enable set, run off-state 0 disables both outputs, 1 enables both, and a low channel enable gives its inactive level.
// - with primary output enable clear, idle off-state 0 disables both outputs, 1 enables each output whose channel enable is set.
// - run and idle off-state bits ignore writes while the lock level is 10 or 11.
// - the configured dead time delays the activating edge of each output transition.
// - code bits 7:5 of 0xx give a dead time of the whole code in base periods.
// - code bits 7:5 of 10x give 64 plus bits 5:0, times two base periods.
// - code bits 7:5 of 110 give 32 plus bits 4:0, times eight base periods.
// - code bits 7:5 of 111 give 32 plus bits 4:0, times sixteen base periods.
// - the dead-time code is written only while the lock level is 00.
// - the override register sits at byte offset 0x84 and is reached by whole words.
// - the override register resets to all zeros.

package chan2_dt_pkg;

	// ****************************************
	// register map
	// ****************************************
	localparam int          ADDR_W      = 8;
	localparam int          DATA_W      = 32;
	localparam logic [7:0]  OFS_OVERRIDE = 8'h84;
	localparam logic [7:0]  OFS_STATUS   = 8'h90;
	localparam logic [31:0] OVERRIDE_RST = 32'h0000_0000;

	// override register fields
	localparam int BIT_SELECT   = 31;
	localparam int BIT_RUN_OFF  = 11;
	localparam int BIT_IDLE_OFF = 10;
	localparam int CODE_MSB     = 7;
	localparam int CODE_LSB     = 0;

	// status register fields
	localparam int BIT_ST_MAIN  = 0;
	localparam int BIT_ST_COMPL = 1;
	localparam int BIT_ST_BUSY  = 2;
	localparam int BIT_ST_SRC   = 3;
	localparam int ST_LEN_LSB   = 4;
	localparam int ST_LEN_MSB   = 13;

	// lock levels
	localparam logic [1:0] LOCK_OPEN = 2'b00;

	// ****************************************
	// dead-time timing
	// ****************************************
	localparam int         DT_LEN_W     = 10;
	localparam int         CLK_PERIOD_NS = 4;
	localparam int         DTS_PERIOD_NS = 4;
	localparam logic [3:0] DTS_CYCLES    = 4'(DTS_PERIOD_NS / CLK_PERIOD_NS);

	// dead-time inserter states
	typedef enum logic [1:0] {
		DT_LOW       = 2'b00,
		DT_WAIT_HIGH = 2'b01,
		DT_HIGH      = 2'b10,
		DT_WAIT_LOW  = 2'b11
	} dt_state_t;

endpackage

// File: dt_code_decoder.sv
// piecewise decode of the 8-bit dead-time code into base periods
// assumes the code is stable for the cycle it is used in
`timescale 1ns/1ns
`default_nettype none

module dt_code_decoder (
	// code in
	input  wire logic [7:0]                      code_i,
	// length out, in base periods
	output logic      [chan2_dt_pkg::DT_LEN_W-1:0] length_o
);

	// widest result is 63 * 16 = 1008, which fits ten bits
	function automatic logic [chan2_dt_pkg::DT_LEN_W-1:0] decode_len(input logic [7:0] c);
		logic [chan2_dt_pkg::DT_LEN_W-1:0] r;
		r = '0;
		if (!c[7]) begin
			r = {2'h0, c};
		end else if (!c[6]) begin
			r = {2'h0, 1'h1, c[5:0], 1'h0};
		end else if (!c[5]) begin
			r = {1'h0, 1'h1, c[4:0], 3'h0};
		end else begin
			r = {1'h1, c[4:0], 4'h0};
		end
		return r;
	endfunction

	// pure combinational decode
	assign length_o = decode_len(code_i);

endmodule

`default_nettype wire

// File: dt_edge_delay.sv
// dead-time inserter: splits one reference into main and complement drives
// assumes ref_i is synchronous to core_clk_i
`timescale 1ns/1ns
`default_nettype none

module dt_edge_delay (
	// clock and reset
	input  wire logic                              core_clk_i,
	input  wire logic                              rst_n_i,
	input  wire logic                              clk_en_i,
	// reference and length
	input  wire logic                              ref_i,
	input  wire logic [chan2_dt_pkg::DT_LEN_W-1:0] length_i,
	// raw drives
	output logic                                   main_raw_o,
	output logic                                   compl_raw_o,
	output logic                                   busy_o
);

	chan2_dt_pkg::dt_state_t              state_reg;
	logic [chan2_dt_pkg::DT_LEN_W-1:0]    cnt_reg;
	logic [3:0]                           pre_reg;
	logic                                 tick;

	// base period prescaler on the timer clock
	assign tick = (pre_reg == 4'h0);

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			pre_reg <= 4'h0;
		end else if (clk_en_i) begin
			pre_reg <= tick ? 4'(chan2_dt_pkg::DTS_CYCLES - 4'h1) : 4'(pre_reg - 4'h1);
		end
	end

	// a reference edge starts a wait of length_i base periods before the new drive
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			state_reg <= chan2_dt_pkg::DT_LOW;
			cnt_reg   <= '0;
		end else if (clk_en_i) begin
			case (state_reg)
				chan2_dt_pkg::DT_LOW: begin
					if (ref_i) begin
						cnt_reg   <= length_i;
						state_reg <= (length_i == '0) ? chan2_dt_pkg::DT_HIGH
						                              : chan2_dt_pkg::DT_WAIT_HIGH;
					end
				end
				chan2_dt_pkg::DT_WAIT_HIGH: begin
					if (!ref_i) begin
						cnt_reg   <= length_i; // pulse shorter than dead time
						state_reg <= chan2_dt_pkg::DT_WAIT_LOW;
					end else if (tick) begin
						cnt_reg <= cnt_reg - 1'b1;
						if (cnt_reg <= 10'h001) begin
							state_reg <= chan2_dt_pkg::DT_HIGH;
						end
					end
				end
				chan2_dt_pkg::DT_HIGH: begin
					if (!ref_i) begin
						cnt_reg   <= length_i;
						state_reg <= (length_i == '0) ? chan2_dt_pkg::DT_LOW
						                              : chan2_dt_pkg::DT_WAIT_LOW;
					end
				end
				chan2_dt_pkg::DT_WAIT_LOW: begin
					if (ref_i) begin
						cnt_reg   <= length_i;
						state_reg <= chan2_dt_pkg::DT_WAIT_HIGH;
					end else if (tick) begin
						cnt_reg <= cnt_reg - 1'b1;
						if (cnt_reg <= 10'h001) begin
							state_reg <= chan2_dt_pkg::DT_LOW;
						end
					end
				end
				default: begin
					state_reg <= chan2_dt_pkg::DT_LOW;
				end
			endcase
		end
	end

	// drives are decoded from state so neither side ever overlaps the other
	assign main_raw_o  = (state_reg == chan2_dt_pkg::DT_HIGH);
	assign compl_raw_o = (state_reg == chan2_dt_pkg::DT_LOW);
	assign busy_o      = state_reg[0];

endmodule

`default_nettype wire
